// File: src/logical_instruction_unit.sv
// logical instruction datapath with apb register access
`timescale 1ns/1ps
`default_nettype none
module logical_instruction_unit (
    input  wire logic                      core_clk,
    input  wire logic                      resetn,
    input  wire logic                      issueValid,
    input  wire logic_unit_pkg::instr_t    issueInstr,
    output logic                           issueReady,
    output logic                           execDone,
    output logic [1:0]                     condCode,
    output logic_unit_pkg::mem_req_t       memReq,
    input  wire logic_unit_pkg::mem_rsp_t  memRsp,
    input  wire logic_unit_pkg::apb_req_t  apbReq,
    output logic_unit_pkg::apb_rsp_t       apbRsp
);
    import logic_unit_pkg::*;

    typedef struct packed {
        unit_state_t st;
        instr_t      instr;
        op_kind_t    kind;
        logic_op_t   lop;
        logic        dbl;
        logic        needB;
        logic [63:0] opnd;
        logic [31:0] accA;
        logic [31:0] accB;
        logic [17:0] bAddr;
        logic        wordIdx;
        mem_req_t    mem;
        apb_rsp_t    apb;
        logic        ready;
        logic        done;
        logic [1:0]  cond;
    } state_t;

    state_t      state_q;
    state_t      state_d;
    logic [63:0] aluX;
    logic [63:0] aluY;
    logic [63:0] aluZ;
    logic [4:0]  bytePos;

    // byte 0 is the leftmost, so position counts down from the top
    assign bytePos = {~state_q.instr.mField, 3'h0}; // RULE3

    always_comb begin
        aluX = '0;
        aluY = state_q.opnd;
        case (state_q.kind)
            KIND_BYTE: begin
                aluX[BYTE_W-1:0] = state_q.accA[bytePos +: BYTE_W]; // RULE1 RULE2
            end
            KIND_HALF: begin
                case (state_q.instr.mField) // RULE17
                    HALF_LEFT:  aluX[HALF_W-1:0] = state_q.accA[WORD_W-1:HALF_W];
                    HALF_RIGHT: aluX[HALF_W-1:0] = state_q.accA[HALF_W-1:0];
                    default: begin
                        aluX[WORD_W-1:0] = state_q.accA; // RULE18
                        aluY = {32'h0, {HALF_W{state_q.opnd[HALF_W-1]}}, state_q.opnd[HALF_W-1:0]};
                    end
                endcase
            end
            default: begin
                case (state_q.instr.mField) // RULE12 RULE13
                    SEL_A:   aluX[WORD_W-1:0] = state_q.accA;
                    SEL_B:   aluX[WORD_W-1:0] = state_q.accB;
                    default: aluX = {state_q.accA, state_q.accB};
                endcase
            end
        endcase
    end

    // one cell per bit position, so no bit can see its neighbour
    for (genvar i = 0; i < DWORD_W; i++) begin : gBit
        assign aluZ[i] = (state_q.lop == LOP_AND) ? (aluX[i] & aluY[i]) :
                         (state_q.lop == LOP_OR)  ? (aluX[i] | aluY[i]) :
                                                    (aluX[i] ^ aluY[i]); // RULE14
    end

    always_comb begin
        logic        take;
        logic        ok;
        logic        lit;
        logic        busyNow;
        logic        refuse;
        logic [31:0] newA;
        logic [31:0] newB;
        logic [63:0] exam;
        logic        allOnes;
        logic        allZeros;
        op_kind_t    k;
        logic_op_t   lop;
        take     = issueValid && state_q.ready;
        ok       = 1'b1;
        lit      = 1'b0;
        busyNow  = 1'b0;
        refuse   = 1'b0;
        newA     = state_q.accA;
        newB     = state_q.accB;
        exam     = '0;
        allOnes  = 1'b0;
        allZeros = 1'b0;
        k        = KIND_WORD;
        lop      = LOP_AND;
        state_d  = state_q;

        case (state_q.st)
            ST_IDLE: begin
                if (take) begin
                    case (issueInstr.opcode)
                        OP_AND_BYTE: begin
                            k = KIND_BYTE; // RULE1
                            lop = LOP_AND;
                        end
                        OP_OR_BYTE: begin
                            k = KIND_BYTE; // RULE2
                            lop = LOP_OR;
                        end
                        OP_OR_HALF: begin
                            k = KIND_HALF; // RULE16
                            lop = LOP_OR;
                        end
                        OP_OR_ACC: begin
                            k = KIND_WORD; // RULE10
                            lop = LOP_OR;
                        end
                        OP_XOR_ACC: begin
                            k = KIND_WORD; // RULE11
                            lop = EXCLUSIVE_OR_OP;
                        end
                        OP_AND_STORE: begin
                            k = KIND_STORE; // RULE6
                            lop = LOP_AND;
                        end
                        OP_OR_STORE: begin
                            k = KIND_STORE; // RULE7
                            lop = LOP_OR;
                        end
                        default: ok = 1'b0;
                    endcase
                    // select code 00 has no meaning outside the byte forms
                    if (k != KIND_BYTE && issueInstr.mField == 2'h0) begin
                        ok = 1'b0;
                    end
                    lit = issueInstr.literal && (k != KIND_STORE); // RULE9
                    state_d.instr   = issueInstr;
                    state_d.kind    = k;
                    state_d.lop     = lop;
                    state_d.wordIdx = 1'b0;
                    state_d.dbl     = (k == KIND_WORD || k == KIND_STORE) && issueInstr.mField == SEL_D;
                    state_d.needB   = (k == KIND_WORD || k == KIND_STORE) &&
                                      (issueInstr.mField == SEL_B || issueInstr.mField == SEL_D);
                    state_d.opnd    = '0;
                    if (!ok) begin
                        state_d.st = ST_FINISH;
                    end else if (lit) begin
                        case (k)
                            KIND_BYTE: state_d.opnd[BYTE_W-1:0] = issueInstr.addrField[BYTE_W-1:0]; // RULE5
                            KIND_HALF: state_d.opnd[HALF_W-1:0] = issueInstr.addrField[HALF_W-1:0]; // RULE19
                            default: begin
                                state_d.opnd = {{(DWORD_W-ADDR_W){issueInstr.addrField[ADDR_W-1]}},
                                                issueInstr.addrField}; // RULE15
                                if (issueInstr.mField != SEL_D) begin
                                    state_d.opnd[DWORD_W-1:WORD_W] = '0;
                                end
                            end
                        endcase
                        if (state_d.needB) begin
                            state_d.st       = ST_RDB;
                            state_d.mem.req  = 1'b1;
                            state_d.mem.we   = 1'b0;
                            state_d.mem.addr = state_q.bAddr;
                        end else begin
                            state_d.st = ST_EXEC;
                        end
                    end else begin
                        state_d.st       = ST_RDOP;
                        state_d.mem.req  = 1'b1;
                        state_d.mem.we   = 1'b0;
                        state_d.mem.addr = issueInstr.effAddr;
                    end
                end
            end
            ST_RDOP: begin
                if (memRsp.ack) begin
                    case (state_q.kind)
                        KIND_BYTE: begin
                            // memory returns the aligned word; pick the byte it names
                            state_d.opnd[BYTE_W-1:0] =
                                memRsp.rdata[{~state_q.instr.effAddr[1:0], 3'h0} +: BYTE_W];
                        end
                        KIND_HALF: begin
                            state_d.opnd[HALF_W-1:0] =
                                memRsp.rdata[{~state_q.instr.effAddr[1], 4'h0} +: HALF_W];
                        end
                        default: begin
                            if (state_q.dbl && !state_q.wordIdx) begin
                                state_d.opnd[DWORD_W-1:WORD_W] = memRsp.rdata; // RULE13
                            end else begin
                                state_d.opnd[WORD_W-1:0] = memRsp.rdata;
                            end
                        end
                    endcase
                    if (state_q.dbl && !state_q.wordIdx) begin
                        state_d.wordIdx  = 1'b1;
                        state_d.mem.addr = state_q.instr.effAddr + WORD_STEP;
                    end else if (state_q.needB) begin
                        state_d.st       = ST_RDB;
                        state_d.mem.addr = state_q.bAddr;
                    end else begin
                        state_d.st      = ST_EXEC;
                        state_d.mem.req = 1'b0;
                    end
                end
            end
            ST_RDB: begin
                if (memRsp.ack) begin
                    // B lives in memory, so it is reread for every use
                    state_d.accB    = memRsp.rdata;
                    state_d.mem.req = 1'b0;
                    state_d.st      = ST_EXEC;
                end
            end
            ST_EXEC: begin
                case (state_q.kind)
                    KIND_BYTE: begin
                        newA[bytePos +: BYTE_W] = aluZ[BYTE_W-1:0]; // RULE1 RULE2
                        exam[WORD_W-1:0] = newA; // RULE4
                    end
                    KIND_HALF: begin
                        case (state_q.instr.mField)
                            HALF_LEFT:  newA[WORD_W-1:HALF_W] = aluZ[HALF_W-1:0]; // RULE16
                            HALF_RIGHT: newA[HALF_W-1:0] = aluZ[HALF_W-1:0];
                            default:    newA = aluZ[WORD_W-1:0]; // RULE18
                        endcase
                        exam[WORD_W-1:0] = newA;
                    end
                    KIND_WORD: begin
                        case (state_q.instr.mField) // RULE12
                            SEL_A: newA = aluZ[WORD_W-1:0];
                            SEL_B: newB = aluZ[WORD_W-1:0];
                            default: begin
                                newA = aluZ[DWORD_W-1:WORD_W];
                                newB = aluZ[WORD_W-1:0];
                            end
                        endcase
                        exam = state_q.dbl ? {newA, newB} :
                               {32'h0, (state_q.instr.mField == SEL_A) ? newA : newB};
                    end
                    default: begin
                        exam = aluZ; // RULE8
                    end
                endcase
                allOnes  = state_q.dbl ? (&exam) : (&exam[WORD_W-1:0]); // RULE22
                allZeros = state_q.dbl ? ~(|exam) : ~(|exam[WORD_W-1:0]);
                if (state_q.instr.cEnable) begin // RULE20
                    state_d.cond = allOnes ? COND_ONES : (allZeros ? COND_ZEROS : COND_MIXED); // RULE21
                end
                state_d.accA    = newA;
                state_d.accB    = newB;
                state_d.opnd    = aluZ;
                state_d.wordIdx = 1'b0;
                if (state_q.kind == KIND_STORE) begin
                    state_d.st        = ST_WRMEM; // RULE6 RULE7
                    state_d.mem.req   = 1'b1;
                    state_d.mem.we    = 1'b1;
                    state_d.mem.addr  = state_q.instr.effAddr;
                    state_d.mem.wdata = state_q.dbl ? aluZ[DWORD_W-1:WORD_W] : aluZ[WORD_W-1:0];
                end else if (state_q.needB) begin
                    state_d.st        = ST_WRMEM;
                    state_d.mem.req   = 1'b1;
                    state_d.mem.we    = 1'b1;
                    state_d.mem.addr  = state_q.bAddr;
                    state_d.mem.wdata = newB;
                end else begin
                    state_d.st = ST_FINISH;
                end
            end
            ST_WRMEM: begin
                if (memRsp.ack) begin
                    if (state_q.kind == KIND_STORE && state_q.dbl && !state_q.wordIdx) begin
                        state_d.wordIdx   = 1'b1;
                        state_d.mem.addr  = state_q.instr.effAddr + WORD_STEP;
                        state_d.mem.wdata = state_q.opnd[WORD_W-1:0];
                    end else begin
                        state_d.mem = '0;
                        state_d.st  = ST_FINISH;
                    end
                end
            end
            ST_FINISH: begin
                state_d.st = ST_IDLE;
            end
            default: begin
                state_d.st  = ST_IDLE;
                state_d.mem = '0;
            end
        endcase

        // apb: answer one cycle after setup; writes land at the access edge
        busyNow = (state_q.st != ST_IDLE) || take;
        if (apbReq.psel && !apbReq.penable && !state_q.apb.pready) begin
            refuse = apbReq.pwrite && busyNow &&
                     (apbReq.paddr == REG_ACC_A || apbReq.paddr == REG_B_ADDR);
            state_d.apb.pready  = 1'b1;
            state_d.apb.prdata  = '0;
            state_d.apb.pslverr = refuse;
            case (apbReq.paddr)
                REG_ACC_A:  state_d.apb.prdata = state_q.accA;
                REG_B_ADDR: state_d.apb.prdata[ADDR_W-1:0] = state_q.bAddr;
                REG_STATUS: begin
                    state_d.apb.prdata[1:0] = state_q.cond;
                    state_d.apb.prdata[STAT_BUSY_BIT] = state_q.st != ST_IDLE;
                end
                default:    state_d.apb.pslverr = 1'b1;
            endcase
        end else if (apbReq.psel && apbReq.penable && state_q.apb.pready) begin
            if (apbReq.pwrite && !state_q.apb.pslverr) begin
                if (apbReq.paddr == REG_ACC_A) begin
                    state_d.accA = apbReq.pwdata;
                end
                if (apbReq.paddr == REG_B_ADDR) begin
                    state_d.bAddr = apbReq.pwdata[ADDR_W-1:0];
                end
            end
            state_d.apb = '0;
        end

        // issue is held off while the unit is not idle or pready is up; an A or B address write whose setup meets an issue or a busy unit gets pslverr
        state_d.ready = (state_d.st == ST_IDLE) && !state_d.apb.pready;
        state_d.done  = (state_d.st == ST_FINISH);
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q       <= '0;
            state_q.st    <= ST_IDLE;
            state_q.kind  <= KIND_BYTE;
            state_q.lop   <= LOP_AND;
            state_q.accA  <= ACC_A_RESET;
            state_q.bAddr <= B_ADDR_RESET;
            state_q.cond  <= COND_RESET;
            state_q.ready <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    assign issueReady = state_q.ready;
    assign execDone   = state_q.done;
    assign condCode   = state_q.cond;
    assign memReq     = state_q.mem;
    assign apbRsp     = state_q.apb;
endmodule
`default_nettype wire

// File: src/logic_unit_pkg.sv
// package: constants and carrier types for the logical instruction unit
// Notes on behaviour
// RULE1 - opcode 20 ANDs memory byte into A
// RULE2 - opcode 21 ORs memory byte into A
// RULE3 - byte select 00 leftmost through 11 rightmost
// RULE4 - byte ops: condition over whole A
// RULE5 - byte literal uses rightmost 8 address bits
// RULE6 - opcode 64 ANDs accumulator into memory
// RULE7 - opcode 65 ORs accumulator into memory
// RULE8 - store ops: condition over memory result
// RULE9 - store ops: direct or indirect, never literal
// RULE10 - opcode 25 ORs operand into accumulator
// RULE11 - opcode 27 XORs operand into accumulator
// RULE12 - select 01 A, 10 B, 11 D
// RULE13 - width 32 bits, or 64 for D
// RULE14 - operation applied per corresponding bit pair
// RULE15 - word literal sign-extends 18-bit address field
// RULE16 - opcode 31 ORs half-word into A half
// RULE17 - half select 01 left, 10 right, 11 sign-extended
// RULE18 - sign-extended half ORs across whole A
// RULE19 - half literal uses rightmost 16 address bits
// RULE20 - condition enable zero leaves indicator alone
// RULE21 - indicator 1 ones, 2 zeros, 3 mixed
// RULE22 - indicator taken from final full-width result
package logic_unit_pkg;
    localparam int BYTE_W  = 8;
    localparam int HALF_W  = 16;
    localparam int ADDR_W  = 18;
    localparam int WORD_W  = 32;
    localparam int DWORD_W = 64;

    localparam logic [7:0] OP_AND_BYTE  = 8'h20;
    localparam logic [7:0] OP_OR_BYTE   = 8'h21;
    localparam logic [7:0] OP_OR_ACC    = 8'h25;
    localparam logic [7:0] OP_XOR_ACC   = 8'h27;
    localparam logic [7:0] OP_OR_HALF   = 8'h31;
    localparam logic [7:0] OP_AND_STORE = 8'h64;
    localparam logic [7:0] OP_OR_STORE  = 8'h65;

    localparam logic [1:0] SEL_A      = 2'h1;
    localparam logic [1:0] SEL_B      = 2'h2;
    localparam logic [1:0] SEL_D      = 2'h3;
    localparam logic [1:0] HALF_LEFT  = 2'h1;
    localparam logic [1:0] HALF_RIGHT = 2'h2;
    localparam logic [1:0] HALF_SEXT  = 2'h3;

    localparam logic [1:0] COND_RESET = 2'h0;
    localparam logic [1:0] COND_ONES  = 2'h1;
    localparam logic [1:0] COND_ZEROS = 2'h2;
    localparam logic [1:0] COND_MIXED = 2'h3;

    localparam logic [17:0] WORD_STEP    = 18'h00004;
    localparam logic [17:0] B_ADDR_RESET = 18'h00000;
    localparam logic [31:0] ACC_A_RESET  = 32'h00000000;

    localparam logic [7:0] REG_ACC_A  = 8'h00;
    localparam logic [7:0] REG_B_ADDR = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam int STAT_BUSY_BIT = 2;

    typedef struct packed {
        logic [7:0]  opcode;
        logic [1:0]  mField;
        logic        cEnable;
        logic        literal;
        logic [17:0] addrField;
        logic [17:0] effAddr;
    } instr_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [17:0] addr;
        logic [31:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } mem_rsp_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

    typedef enum logic [1:0] {
        LOP_AND          = 2'h0,
        LOP_OR           = 2'h1,
        EXCLUSIVE_OR_OP  = 2'h2
    } logic_op_t;

    typedef enum logic [1:0] {
        KIND_BYTE  = 2'h0,
        KIND_HALF  = 2'h1,
        KIND_WORD  = 2'h2,
        KIND_STORE = 2'h3
    } op_kind_t;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_RDOP   = 6'h02,
        ST_RDB    = 6'h04,
        ST_EXEC   = 6'h08,
        ST_WRMEM  = 6'h10,
        ST_FINISH = 6'h20
    } unit_state_t;
endpackage

// File: dv/lu_mem_model.sv
// memory exchange model answering the unit's word requests
`timescale 1ns/1ps
`default_nettype none
module lu_mem_model (
    input  wire logic                     core_clk,
    input  wire logic                     resetn,
    input  wire logic [1:0]               lat,
    input  wire logic_unit_pkg::mem_req_t memReq,
    output var  logic_unit_pkg::mem_rsp_t memRsp
);
    import logic_unit_pkg::*;
    logic [31:0] mem [256];
    logic [1:0]  waitCnt;
    // ack is registered: one wait cycle is the fastest answer
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            memRsp <= '0;
            waitCnt <= '0;
        end else if (memRsp.ack) begin
            // data not valid outside the ack cycle
            memRsp <= '{ack: 1'b0, rdata: ~memRsp.rdata};
            waitCnt <= '0;
        end else if (memReq.req && waitCnt >= lat) begin
            memRsp <= '{ack: 1'b1, rdata: mem[memReq.addr[9:2]]};
            if (memReq.we) begin
                mem[memReq.addr[9:2]] <= memReq.wdata;
            end
        end else if (memReq.req) begin
            waitCnt <= waitCnt + 2'h1;
        end
    end
endmodule
`default_nettype wire

// File: dv/lu_properties.sv
// port checker for the logical instruction unit
`timescale 1ns/1ps
`default_nettype none
module lu_properties (
    input wire logic                     core_clk,
    input wire logic                     resetn,
    input wire logic                     issueValid,
    input wire logic_unit_pkg::instr_t   issueInstr,
    input wire logic                     issueReady,
    input wire logic                     execDone,
    input wire logic [1:0]               condCode,
    input wire logic_unit_pkg::mem_req_t memReq,
    input wire logic_unit_pkg::mem_rsp_t memRsp,
    input wire logic_unit_pkg::apb_req_t apbReq,
    input wire logic_unit_pkg::apb_rsp_t apbRsp
);
    import logic_unit_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    typedef struct packed {logic cen; logic st; logic [1:0] m; logic [31:0] w;} hold_t;
    hold_t h_q, h_d;
    wire logic [7:0] op = issueInstr.opcode;
    wire logic [1:0] m = issueInstr.mField;
    wire logic take = issueValid && issueReady;
    wire logic st = op inside {OP_AND_STORE, OP_OR_STORE};
    wire logic byt = op inside {OP_AND_BYTE, OP_OR_BYTE};
    wire logic litA = take && issueInstr.literal && (byt || (op == OP_OR_HALF && m != 2'h0)
                      || (op inside {OP_OR_ACC, OP_XOR_ACC} && m == SEL_A));
    wire logic bad = take && (!(op inside {OP_OR_ACC, OP_XOR_ACC, OP_OR_HALF}) && !byt && !st
                     || !byt && m == 2'h0);
    always_comb begin
        h_d = h_q;
        if (take) begin
            h_d.cen = issueInstr.cEnable;
            h_d.st = st;
            h_d.m = m;
        end
        if (memReq.req && memReq.we && memRsp.ack) begin
            h_d.w = memReq.wdata;
        end
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            h_q <= '0;
        end else begin
            h_q <= h_d;
        end
    end
    AST_BUSY: assert property (take |=> !issueReady) else $error("ready while busy");
    AST_LIT_NOMEM: assert property (litA |=> (!memReq.req)[*2])
        else $error("literal read memory");
    AST_LIT_DONE: assert property (litA |-> ##2 execDone)
        else $error("literal late");
    AST_BAD_NOP: assert property (bad |=> execDone && $stable(condCode))
        else $error("invalid not a no-op");
    AST_STORE_RD: assert property (take && st && m != 2'h0 |=> memReq.req && !memReq.we
        && memReq.addr == $past(issueInstr.effAddr)) else $error("store read missing");
    AST_STORE_WR: assert property (take && st && m != 2'h0 |-> ##[2:40] (memReq.req && memReq.we))
        else $error("store write missing");
    AST_NO_COND: assert property (execDone && !h_q.cen |-> $stable(condCode))
        else $error("indicator moved");
    AST_STORE_COND: assert property (execDone && h_q.cen && h_q.st && h_q.m == SEL_A
        |-> condCode == ((&h_q.w) ? COND_ONES : ((|h_q.w) ? COND_MIXED : COND_ZEROS)))
        else $error("store indicator wrong");
    AST_APB_READY: assert property (apbReq.psel && !apbReq.penable |=> apbRsp.pready)
        else $error("apb not answered");
    cover property (litA);
    cover property (execDone && h_q.st);
    cover property (bad);
endmodule
bind logical_instruction_unit lu_properties chk_u (.*);
`default_nettype wire

// File: dv/testbench.sv
// self-checking bench for the logical instruction unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import logic_unit_pkg::*;
    typedef struct packed {
        logic [7:0] op; logic [1:0] m; logic c, lit; logic [17:0] af, ea;
        logic [31:0] aIn, mIn, aExp, mExp; logic [1:0] cExp;
    } row_t;
    logic        core_clk = 1'b0;
    logic        resetn;
    logic        issueValid = 1'b0;
    instr_t      issueInstr = '0;
    logic        issueReady, execDone, err;
    logic [1:0]  condCode, cc, memLat = 2'h0;
    mem_req_t    memReq;
    mem_rsp_t    memRsp;
    apb_req_t    apbReq = '0;
    apb_rsp_t    apbRsp;
    logic [31:0] rd;
    int          bad_count = 0, checks_done = 0;
    row_t        rows [12];
    always #20 core_clk = ~core_clk;
    logical_instruction_unit dut_u (.core_clk(core_clk), .resetn(resetn), .issueValid(issueValid),
        .issueInstr(issueInstr), .issueReady(issueReady), .execDone(execDone), .condCode(condCode),
        .memReq(memReq), .memRsp(memRsp), .apbReq(apbReq), .apbRsp(apbRsp));
    lu_mem_model mem_u (.core_clk(core_clk), .resetn(resetn), .lat(memLat), .memReq(memReq), .memRsp(memRsp));
    task automatic checkVal(input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    task automatic checkCond(input logic [1:0] exp, input logic [1:0] got);
        checkVal({30'h0, exp}, {30'h0, got});
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic apbXfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        apbReq <= '{1'b1, 1'b0, wr, a, wd};
        @(posedge core_clk);
        apbReq.penable <= 1'b1;
        do @(posedge core_clk); while (apbRsp.pready !== 1'b1);
        rd = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq <= '0;
    endtask
    task automatic issue(input instr_t ins);
        @(posedge core_clk);
        issueValid <= 1'b1;
        issueInstr <= ins;
        do @(posedge core_clk); while (issueReady !== 1'b1);
        issueValid <= 1'b0;
        while (execDone !== 1'b1) @(posedge core_clk);
        cc = condCode;
    endtask
    initial begin
        repeat (5000) @(posedge core_clk);
        bad_count++;
        wrap_up();
    end
    initial begin
        resetn <= 1'b0;
        rows = '{
        '{8'h20,2'h0,1'b1,1'b0,18'h0,18'h10,32'h12345678,32'h0f000000,32'h02345678,32'h0f000000,2'h3},
        '{8'h21,2'h3,1'b1,1'b0,18'h0,18'h13,32'hffffff0f,32'h000000f0,32'hffffffff,32'h000000f0,2'h1},
        '{8'h21,2'h1,1'b1,1'b1,18'h3ffa5,18'h0,32'h0,32'h0,32'h00a50000,32'h0,2'h3},
        '{8'h64,2'h1,1'b1,1'b0,18'h0,18'h10,32'hf0f0f0f0,32'hffff0000,32'hf0f0f0f0,32'hf0f00000,2'h3},
        '{8'h65,2'h1,1'b1,1'b1,18'h0,18'h10,32'hf0f0f0f0,32'h0f0f0f0f,32'hf0f0f0f0,32'hffffffff,2'h1},
        '{8'h25,2'h1,1'b1,1'b1,18'h20000,18'h0,32'h1,32'h0,32'hfffe0001,32'h0,2'h3},
        '{8'h27,2'h1,1'b1,1'b0,18'h0,18'h10,32'hffffffff,32'hffffffff,32'h0,32'hffffffff,2'h2},
        '{8'h27,2'h1,1'b0,1'b0,18'h0,18'h10,32'h00ff00ff,32'h0000ffff,32'h00ffff00,32'h0000ffff,2'h2},
        '{8'h31,2'h1,1'b1,1'b0,18'h0,18'h12,32'h0,32'h00001234,32'h12340000,32'h00001234,2'h3},
        '{8'h31,2'h2,1'b1,1'b1,18'h08001,18'h0,32'hffff0000,32'h0,32'hffff8001,32'h0,2'h3},
        '{8'h31,2'h3,1'b1,1'b0,18'h0,18'h10,32'h00007fff,32'h80000000,32'hffffffff,32'h80000000,2'h1},
        '{8'h25,2'h0,1'b1,1'b0,18'h0,18'h10,32'h12345678,32'hffffffff,32'h12345678,32'hffffffff,2'h1}};
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        checkCond(COND_RESET, condCode);
        foreach (rows[i]) begin
            memLat <= 2'(i % 3);
            mem_u.mem[4] = rows[i].mIn;
            apbXfer(1'b1, REG_ACC_A, rows[i].aIn);
            issue('{rows[i].op, rows[i].m, rows[i].c, rows[i].lit, rows[i].af, rows[i].ea});
            apbXfer(1'b0, REG_ACC_A, 32'h0);
            checkVal(rows[i].aExp, rd);
            checkVal(rows[i].mExp, mem_u.mem[4]);
            checkCond(rows[i].cExp, cc);
        end
        // D = {A, B}; B lives in memory
        mem_u.mem[8] = 32'h0000000f;
        mem_u.mem[12] = 32'h0f000000;
        mem_u.mem[13] = 32'hfffffff0;
        apbXfer(1'b1, REG_B_ADDR, 32'h20);
        apbXfer(1'b1, REG_ACC_A, 32'hf0000000);
        issue('{OP_OR_ACC, SEL_D, 1'b1, 1'b0, 18'h0, 18'h30});
        apbXfer(1'b0, REG_ACC_A, 32'h0);
        checkVal(32'hff000000, rd);
        checkVal(32'hffffffff, mem_u.mem[8]);
        checkCond(COND_MIXED, cc);
        apbXfer(1'b0, REG_STATUS, 32'h0);
        checkVal(32'h3, rd);
        apbXfer(1'b0, 8'h0c, 32'h0);
        checkVal(32'h1, {31'h0, err});
        checkVal(32'h0, rd);
        wrap_up();
    end
endmodule
`default_nettype wire
